// [bench/serial_far_end.sv]
// Far-end model: the remote link as the flag logic sees it.
// Assumes bench commands change just after a rising edge of hclk.
`timescale 1ns/100ps
module serial_far_end
(
  // Clock
  input  wire logic       hclk,
  // Command from the bench
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_kind,
  input  wire logic       cmd_stop,
  input  wire logic       cmd_ninth,
  input  wire logic [1:0] cmd_gap,
  output logic            busy,
  // Frame events toward the block
  output logic            rx_frame_done,
  output logic            rx_stop_bit,
  output logic            rx_ninth_bit,
  output logic            tx_data8_done,
  output logic            tx_stop_start
);
  // ************************************************************
  // Event sequencer
  // ************************************************************
  // A command waits cmd_gap cycles, then gives one single-cycle pulse.
  // Off the pulse the bits turn over, so a stale value never passes.
  initial
  begin
    busy          = 1'b0;
    rx_frame_done = 1'b0;
    rx_stop_bit   = 1'b0;
    rx_ninth_bit  = 1'b0;
    tx_data8_done = 1'b0;
    tx_stop_start = 1'b0;
    forever
    begin
      @(posedge hclk);
      if (cmd_valid)
      begin
        busy <= 1'b1;
        repeat (cmd_gap) @(posedge hclk);
        rx_frame_done <= (cmd_kind == 2'h0);
        tx_data8_done <= (cmd_kind == 2'h1);
        tx_stop_start <= (cmd_kind == 2'h2);
        rx_stop_bit   <= cmd_stop;
        rx_ninth_bit  <= cmd_ninth;
        @(posedge hclk);
        rx_frame_done <= 1'b0;
        tx_data8_done <= 1'b0;
        tx_stop_start <= 1'b0;
        rx_stop_bit   <= ~cmd_stop;
        rx_ninth_bit  <= ~cmd_ninth;
        busy          <= 1'b0;
      end
    end
  end
endmodule

// [bench/uart_serial_control_flags_bench.sv]
// Self-checking bench for the serial control and flag register.
// Assumes one bus slave, so hready is looped back from hreadyout.
`timescale 1ns/100ps
module uart_serial_control_flags_bench;
  // Bus and design signals.
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        mode_9bit, rx_frame_done, rx_stop_bit, rx_ninth_bit;
  logic        tx_data8_done, tx_stop_start;
  logic        receive_enable_bit, ninth_tx_bit, mp_filter_enable, serial_irq;
  // Far-end commands.
  logic        cmd_valid, cmd_stop, cmd_ninth, busy;
  logic [1:0]  cmd_kind, cmd_gap;
  // Bench state: counters, expected reads, control image, seed.
  int          err_count, check_count, cyc;
  logic [31:0] exp_q[$];
  logic        dp_rd, acc;
  logic [7:0]  exp_ctrl;
  logic [31:0] seed;
  localparam logic [31:0] CTRL = 32'h0, STAT = 32'h4, MASK = 32'h8;

  uart_serial_control_flags dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .mode_9bit(mode_9bit), .rx_frame_done(rx_frame_done),
    .rx_stop_bit(rx_stop_bit), .rx_ninth_bit(rx_ninth_bit),
    .tx_data8_done(tx_data8_done), .tx_stop_start(tx_stop_start),
    .receive_enable_bit(receive_enable_bit), .ninth_tx_bit(ninth_tx_bit),
    .mp_filter_enable(mp_filter_enable), .serial_irq(serial_irq)
  );

  serial_far_end far
  (
    .hclk(hclk), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_stop(cmd_stop), .cmd_ninth(cmd_ninth), .cmd_gap(cmd_gap),
    .busy(busy), .rx_frame_done(rx_frame_done), .rx_stop_bit(rx_stop_bit),
    .rx_ninth_bit(rx_ninth_bit), .tx_data8_done(tx_data8_done),
    .tx_stop_start(tx_stop_start)
  );

  // ************************************************************
  // Clock, helpers and bus tasks
  // ************************************************************
  // The 8 ns clock.
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Xorshift step for the random values.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // One comparison; four-state equality so an unknown never matches.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One single word transfer; waits on hready, never on a fixed count.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= uart_flags_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    #1;
  endtask

  // A read notes its expected word; the monitor compares it.
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // One far-end event after a random gap of 0 to 3 cycles.
  task automatic ev(input logic [1:0] k, input logic s, input logic n);
    @(posedge hclk);
    cmd_valid <= 1'b1;
    cmd_kind  <= k;
    cmd_stop  <= s;
    cmd_ninth <= n;
    cmd_gap   <= seed[1:0];
    seed = xs(seed);
    @(posedge hclk);
    cmd_valid <= 1'b0;
    do @(posedge hclk); while (busy !== 1'b0);
    #1;
  endtask

  // The interrupt line is a register, so give it two more edges.
  task automatic irq(input logic e);
    repeat (2) @(posedge hclk);
    #1;
    check({31'h0, serial_irq}, {31'h0, e});
  endtask

  // Verdict and end of run.
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ************************************************************
  // Monitor and timeout
  // ************************************************************
  // Read data is taken at the edge that ends the data phase.
  always @(posedge hclk)
  begin
    if (dp_rd && hreadyout === 1'b1)
      check(hrdata, exp_q.pop_front());
    dp_rd <= hsel && hreadyout && htrans[1] && !hwrite;
  end

  // The whole run needs about 450 cycles; 6000 marks a hang.
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_count++;
      results();
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    {hresetn, hsel, hwrite, mode_9bit, cmd_valid, cmd_stop, cmd_ninth} = 7'h0;
    {haddr, hwdata, htrans, cmd_kind, cmd_gap} = 70'h0;
    hsize = uart_flags_pkg::HSIZE_WORD;
    {err_count, check_count, cyc} = {32'h0, 32'h0, 32'h0};
    dp_rd = 1'b0;
    exp_ctrl = 8'h00;
    seed = 32'h49fc9a71;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, an unmapped read and the fixed response.
    rd(CTRL, 32'h0);
    rd(MASK, 32'h0);
    rd(STAT, 32'h0);
    rd(32'h40, 32'h0);
    check({30'h0, hresp, hreadyout}, 32'h1);
    $display("reset test done");
    // Random control values; writes to unmapped places are dropped.
    repeat (4)
    begin
      seed = xs(seed);
      exp_ctrl = {2'h0, seed[5:3], 3'h0};
      wr_any(CTRL, {24'h0, exp_ctrl});
      check({29'h0, mp_filter_enable, receive_enable_bit, ninth_tx_bit}, 32'(seed[5:3]));
      bus(1'b1, 32'h10c, 32'hff);
      bus(1'b1, 32'h100, 32'hff);
      rd(CTRL, {24'h0, exp_ctrl});
    end
    $display("control test done");
    // Receiver off: a frame leaves everything unchanged.
    wr_any(CTRL, 32'h0);
    ev(2'h0, 1'b1, 1'b1);
    rd(CTRL, 32'h0);
    exp_ctrl = 8'h00;
    // Every mode, filter, stop and ninth combination.
    for (int k = 0; k < 16; k++)
    begin
      @(posedge hclk);
      mode_9bit <= k[3];
      exp_ctrl = {2'h0, k[2], 2'h2, exp_ctrl[2], 2'h0};
      wr_any(CTRL, {24'h0, exp_ctrl});
      ev(2'h0, k[1], k[0]);
      acc = !k[2] || (k[3] ? k[0] : k[1]);
      if (acc)
        exp_ctrl[2:0] = {(k[3] ? k[0] : k[1]), 2'h1};
      rd(CTRL, {24'h0, exp_ctrl});
    end
    $display("receive test done");
    // Transmit done sets only on the event of the current mode.
    for (int m = 0; m < 2; m++)
    begin
      @(posedge hclk);
      mode_9bit <= m[0];
      wr_any(CTRL, 32'h08);
      exp_ctrl = {5'h01, exp_ctrl[2], 2'h0};
      ev(2'h2, 1'b0, 1'b0);
      exp_ctrl[1] = m[0];
      rd(CTRL, {24'h0, exp_ctrl});
      bus(1'b1, STAT, 32'h2);
      ev(2'h1, 1'b0, 1'b0);
      exp_ctrl[1] = !m[0];
      rd(CTRL, {24'h0, exp_ctrl});
      check({31'h0, ninth_tx_bit}, 32'h1);
    end
    $display("transmit test done");
    // Interrupt: raise, hold, mask, clear.
    @(posedge hclk);
    mode_9bit <= 1'b0;
    wr_any(CTRL, 32'h10);
    // Byte-sized transfers reach no register: the write drops, the read gives zero.
    @(posedge hclk);
    hsize <= 3'h0;
    bus(1'b1, CTRL, 32'hff);
    rd(CTRL, 32'h0);
    @(posedge hclk);
    hsize <= uart_flags_pkg::HSIZE_WORD;
    rd(CTRL, {24'h0, 5'h02, exp_ctrl[2], 2'h0});
    bus(1'b1, MASK, 32'h2);
    rd(MASK, 32'h2);
    irq(1'b0);
    ev(2'h1, 1'b0, 1'b0);
    irq(1'b1);
    repeat (20) @(posedge hclk);
    irq(1'b1);
    bus(1'b1, MASK, 32'h1);
    irq(1'b0);
    ev(2'h0, 1'b1, 1'b0);
    irq(1'b1);
    rd(STAT, 32'h3);
    bus(1'b1, STAT, 32'h1);
    irq(1'b0);
    rd(STAT, 32'h2);
    bus(1'b1, STAT, 32'h2);
    rd(STAT, 32'h0);
    $display("interrupt test done");
    // A reset in mid-run must bring back the reset values over live state.
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(CTRL, 32'h0);
    rd(MASK, 32'h0);
    check({29'h0, serial_irq, receive_enable_bit, mp_filter_enable}, 32'h0);
    $display("second reset test done");
    repeat (3) @(posedge hclk);
    results();
  end

  // Plain register write.
  task automatic wr_any(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
endmodule

// [hw/ahb_word_port.sv]
// AHB-Lite slave front end: decodes the address phase into a read index
// and a registered write strobe for the data phase.
// Assumes a single slave on the bus, so hready is this slave's hreadyout.
`timescale 1ns/100ps
module ahb_word_port
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite address phase
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  // AHB-Lite data phase
  input  wire logic [31:0] hwdata,
  // Decoded accesses
  output logic             rd_en,
  output logic [5:0]       rd_index,
  output logic             wr_en,
  output logic [5:0]       wr_index,
  output logic [7:0]       wr_data
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed
  {
    logic       wr_pending;   // A write data phase is under way.
    logic [5:0] wr_index;     // Register index captured in the address phase.
  } port_state_t;

  port_state_t s_reg;         // Registered state.
  port_state_t s_next;        // Next state.
  logic        take;          // Address phase accepted this edge.
  logic [5:0]  index;         // Decoded index of the current address.

  // Decode the address phase; anything above 0xff or not a whole word goes
  // to the unmapped index, which reads zero and drops writes.
  always_comb
  begin
    take  = hsel && hready && htrans[1];
    index = uart_flags_pkg::UNMAPPED_INDEX;
    if ((haddr[31:8] == 24'h000000) && (hsize == uart_flags_pkg::HSIZE_WORD))
    begin
      index = haddr[7:2];
    end
    s_next            = s_reg;
    s_next.wr_pending = take && hwrite;
    if (take)
    begin
      s_next.wr_index = index;
    end
  end

  // Register the pending write so it lands with hwdata.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // Reads are served from the address phase; writes from the data phase.
  assign rd_en    = take && !hwrite;
  assign rd_index = index;
  assign wr_en    = s_reg.wr_pending;
  assign wr_index = s_reg.wr_index;
  assign wr_data  = hwdata[7:0];

endmodule

// [hw/rx_accept_filter.sv]
// Receive frame qualifier: decides whether a finished frame is accepted
// and which sampled bit becomes the ninth received bit.
// Assumes frame inputs come from the shifter on the same clock.
`timescale 1ns/100ps
module rx_accept_filter
(
  // Configuration
  input  wire logic mode_9bit,
  input  wire logic mp_enable,
  input  wire logic receive_enable,
  // Frame end from the shifter
  input  wire logic frame_done,
  input  wire logic stop_bit,
  input  wire logic ninth_bit,
  // Decision
  output logic      accept,
  output logic      ninth_value
);

  logic select_bit;           // Bit that the filter looks at.

  // The filter bit is the ninth bit in 9-bit mode, else the stop bit.
  always_comb
  begin
    select_bit  = mode_9bit ? ninth_bit : stop_bit;
    ninth_value = select_bit;
    accept      = 1'b0;
    if (frame_done && receive_enable)
    begin
      accept = mp_enable ? select_bit : 1'b1;
    end
  end

endmodule

// [hw/uart_flags_pkg.sv]
// Constants shared by the serial control and flag logic and its bus port.
// Assumes a single 125 MHz clock domain and a 32-bit AHB-Lite register bus.
package uart_flags_pkg;

  // ****************************************************************
  // Register byte offsets and word indexes
  // ****************************************************************
  // Byte offset of the serial control register.
  localparam logic [7:0] CTRL_OFFSET       = 8'h00;
  // Byte offset of the interrupt status view, write one to clear.
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h04;
  // Byte offset of the interrupt mask register.
  localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h08;
  // Word indexes decoded from haddr[7:2].
  localparam logic [5:0] CTRL_INDEX        = CTRL_OFFSET[7:2];
  localparam logic [5:0] IRQ_STATUS_INDEX  = IRQ_STATUS_OFFSET[7:2];
  localparam logic [5:0] IRQ_MASK_INDEX    = IRQ_MASK_OFFSET[7:2];
  // Index given to every address above 0xff or of a size other than a word.
  localparam logic [5:0] UNMAPPED_INDEX    = 6'h3f;

  // ****************************************************************
  // Field positions of the control register
  // ****************************************************************
  localparam int RX_DONE_POS   = 0;
  localparam int TX_DONE_POS   = 1;
  localparam int NINTH_RX_POS  = 2;
  localparam int NINTH_TX_POS  = 3;
  localparam int RX_ENABLE_POS = 4;
  localparam int MP_ENABLE_POS = 5;

  // ****************************************************************
  // Reset values and bus encodings
  // ****************************************************************
  // Control register after reset: receiver off, flags clear.
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  // Interrupt mask after reset: both sources masked.
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  // Transfer type whose top bit marks an active transfer.
  localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
  // Only whole-word transfers are served.
  localparam logic [2:0] HSIZE_WORD     = 3'h2;
  // OKAY response.
  localparam logic       HRESP_OKAY     = 1'h0;

endpackage

// [hw/uart_serial_control_flags.sv]
// Serial port control and flag register with its interrupt request.
// Assumes the bit shifter runs on hclk and gives one-cycle frame pulses.
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
module uart_serial_control_flags
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Shifter events and mode
  input  wire logic        mode_9bit,
  input  wire logic        rx_frame_done,
  input  wire logic        rx_stop_bit,
  input  wire logic        rx_ninth_bit,
  input  wire logic        tx_data8_done,
  input  wire logic        tx_stop_start,
  // Shifter controls
  output logic             receive_enable_bit,
  output logic             ninth_tx_bit,
  output logic             mp_filter_enable,
  // Interrupt
  output logic             serial_irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed
  {
    logic       hready;       // Ready answer, high from reset onward.
    logic       hresp;        // Response, always OKAY.
    logic [7:0] rdata;        // Read data for the current data phase.
    logic       irq;          // Interrupt request level.
    logic [1:0] mask;         // Interrupt mask, same layout as the status.
    logic       mp_enable;    // Multiprocessor address filter.
    logic       rx_enable;    // Receiver enable.
    logic       ninth_tx;     // Ninth transmit bit.
    logic       ninth_rx;     // Ninth receive bit.
    logic       tx_done;      // Transmit done flag.
    logic       rx_done;      // Receive done flag.
  } flags_state_t;

  flags_state_t s_reg;        // Registered state.
  flags_state_t s_next;       // Next state.

  // Decoded bus accesses.
  logic       rd_en;          // Read address phase accepted.
  logic [5:0] rd_index;       // Register index of the read.
  logic       wr_en;          // Write data phase completes this edge.
  logic [5:0] wr_index;       // Register index of the write.
  logic [7:0] wr_data;        // Low byte of the written word.

  // Receive decision.
  logic       rx_accept;      // Frame accepted by the filter.
  logic       rx_ninth_value; // Bit that becomes the ninth receive bit.
  logic       tx_event;       // Transmit done event for the current mode.
  logic [7:0] ctrl_view;      // Control register as software reads it.

  // ****************************************************************
  // Bus front end and receive filter
  // ****************************************************************
  ahb_word_port u_port
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .hsel     (hsel),
    .haddr    (haddr),
    .htrans   (htrans),
    .hwrite   (hwrite),
    .hsize    (hsize),
    .hready   (hready),
    .hwdata   (hwdata),
    .rd_en    (rd_en),
    .rd_index (rd_index),
    .wr_en    (wr_en),
    .wr_index (wr_index),
    .wr_data  (wr_data)
  );

  rx_accept_filter u_filter
  (
    .mode_9bit      (mode_9bit),
    .mp_enable      (s_reg.mp_enable),
    .receive_enable (s_reg.rx_enable),
    .frame_done     (rx_frame_done),
    .stop_bit       (rx_stop_bit),
    .ninth_bit      (rx_ninth_bit),
    .accept         (rx_accept),
    .ninth_value    (rx_ninth_value)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Software writes are applied first and hardware sets last, so an
  // event landing in the same cycle as a clear is never lost.
  always_comb
  begin
    s_next        = s_reg;
    s_next.hready = 1'b1;
    s_next.hresp  = uart_flags_pkg::HRESP_OKAY;
    if (wr_en)
    begin
      case (wr_index)
        uart_flags_pkg::CTRL_INDEX:
        begin
          // Ninth receive bit is status only and ignores writes.
          s_next.mp_enable = wr_data[uart_flags_pkg::MP_ENABLE_POS];
          s_next.rx_enable = wr_data[uart_flags_pkg::RX_ENABLE_POS];
          s_next.ninth_tx  = wr_data[uart_flags_pkg::NINTH_TX_POS];
          s_next.tx_done   = wr_data[uart_flags_pkg::TX_DONE_POS];
          s_next.rx_done   = wr_data[uart_flags_pkg::RX_DONE_POS];
        end
        uart_flags_pkg::IRQ_STATUS_INDEX:
        begin
          // Writing one clears the flag; zero leaves it.
          if (wr_data[uart_flags_pkg::TX_DONE_POS])
          begin
            s_next.tx_done = 1'b0;
          end
          if (wr_data[uart_flags_pkg::RX_DONE_POS])
          begin
            s_next.rx_done = 1'b0;
          end
        end
        uart_flags_pkg::IRQ_MASK_INDEX:
        begin
          s_next.mask = wr_data[1:0];
        end
        default:
        begin
          // Unmapped writes are dropped.
          s_next.mask = s_reg.mask;
        end
      endcase
    end
    if (rx_accept)
    begin
      s_next.rx_done  = 1'b1;
      s_next.ninth_rx = rx_ninth_value;
    end
    if (tx_event)
    begin
      s_next.tx_done = 1'b1;
    end
    s_next.irq = (s_next.tx_done && s_next.mask[1]) || (s_next.rx_done && s_next.mask[0]);
    // Reads see the state as it stands after this edge's write.
    ctrl_view = {2'h0, s_next.mp_enable, s_next.rx_enable, s_next.ninth_tx,
                 s_next.ninth_rx, s_next.tx_done, s_next.rx_done};
    if (rd_en)
    begin
      case (rd_index)
        uart_flags_pkg::CTRL_INDEX:
        begin
          s_next.rdata = ctrl_view;
        end
        uart_flags_pkg::IRQ_STATUS_INDEX:
        begin
          s_next.rdata = {6'h00, s_next.tx_done, s_next.rx_done};
        end
        uart_flags_pkg::IRQ_MASK_INDEX:
        begin
          s_next.rdata = {6'h00, s_next.mask};
        end
        default:
        begin
          s_next.rdata = 8'h00;
        end
      endcase
    end
  end

  // Transmit done comes after the eighth bit in 8-bit mode and at the
  // start of the stop bit in 9-bit mode; the other pulse is ignored.
  assign tx_event = mode_9bit ? tx_stop_start : tx_data8_done;

  // ****************************************************************
  // State register
  // ****************************************************************
  // All state resets to constants; the ready answer comes up high.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_reg           <= '0;
      s_reg.hready    <= 1'b1;
      s_reg.mask      <= uart_flags_pkg::IRQ_MASK_RESET;
      s_reg.rx_enable <= uart_flags_pkg::CTRL_RESET[uart_flags_pkg::RX_ENABLE_POS];
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hrdata             = {24'h000000, s_reg.rdata};
  assign hreadyout          = s_reg.hready;
  assign hresp              = s_reg.hresp;
  assign receive_enable_bit = s_reg.rx_enable;
  assign ninth_tx_bit       = s_reg.ninth_tx;
  assign mp_filter_enable   = s_reg.mp_enable;
  assign serial_irq         = s_reg.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_rx_mp_pass: assert property (
    (rx_frame_done && s_reg.rx_enable && mode_9bit && s_reg.mp_enable && rx_ninth_bit)
    |=> s_reg.rx_done)
    else $error("Filtered frame with ninth bit one did not set the flag.");

  a_rx_mp_block: assert property (
    (rx_frame_done && mode_9bit && s_reg.mp_enable && !rx_ninth_bit && !s_reg.rx_done
     && !wr_en) |=> !s_reg.rx_done)
    else $error("Filtered frame with ninth bit zero set the flag.");

  a_rx_nofilter: assert property (
    (rx_frame_done && s_reg.rx_enable && mode_9bit && !s_reg.mp_enable)
    |=> s_reg.rx_done)
    else $error("Unfiltered 9-bit frame did not set the flag.");

  a_rx_stop_gate: assert property (
    (rx_frame_done && !mode_9bit && s_reg.mp_enable && !rx_stop_bit && !s_reg.rx_done
     && !wr_en) |=> !s_reg.rx_done)
    else $error("8-bit frame with stop bit zero set the flag.");

  a_rx_disabled: assert property (
    (rx_frame_done && !s_reg.rx_enable && !s_reg.rx_done && !wr_en) |=> !s_reg.rx_done)
    else $error("Frame accepted while the receiver was off.");

  a_ninth_tx_held: assert property (
    !wr_en |=> $stable(ninth_tx_bit))
    else $error("Ninth transmit bit changed without a write.");

  a_ninth_rx_stop: assert property (
    (rx_frame_done && s_reg.rx_enable && !mode_9bit && !s_reg.mp_enable)
    |=> (s_reg.ninth_rx == $past(rx_stop_bit)))
    else $error("Ninth receive bit did not take the stop bit.");

  a_ninth_rx_data: assert property (
    (rx_frame_done && s_reg.rx_enable && mode_9bit && !s_reg.mp_enable)
    |=> (s_reg.ninth_rx == $past(rx_ninth_bit)))
    else $error("Ninth receive bit did not take the ninth data bit.");

  a_tx_done_set: assert property (
    (mode_9bit ? tx_stop_start : tx_data8_done) |=> s_reg.tx_done)
    else $error("Transmit done flag not set at byte end.");

  a_tx_irq: assert property (
    (s_reg.tx_done && s_reg.mask[1]) |-> serial_irq)
    else $error("Unmasked transmit flag raised no interrupt.");

  a_rx_irq: assert property (
    (s_reg.rx_done && s_reg.mask[0]) |-> serial_irq)
    else $error("Unmasked receive flag raised no interrupt.");

  a_flags_sticky: assert property (
    (!wr_en && (s_reg.tx_done || s_reg.rx_done))
    |=> ((s_reg.tx_done || !$past(s_reg.tx_done)) && (s_reg.rx_done || !$past(s_reg.rx_done))))
    else $error("A done flag cleared without a software write.");

  // The event of the other mode must leave the transmit flag alone.
  a_tx_other_event: assert property (
    ((mode_9bit ? (tx_data8_done && !tx_stop_start) : (tx_stop_start && !tx_data8_done))
     && !s_reg.tx_done && !wr_en) |=> !s_reg.tx_done)
    else $error("Transmit done flag set by the event of the other mode.");

  // With every set flag masked the interrupt line stays low.
  a_irq_quiet: assert property (
    !((s_reg.tx_done && s_reg.mask[1]) || (s_reg.rx_done && s_reg.mask[0])) |-> !serial_irq)
    else $error("Interrupt raised with no unmasked flag set.");

  // The ninth receive bit only moves with the end of an enabled frame.
  a_ninth_rx_hold: assert property (
    !(rx_frame_done && s_reg.rx_enable) |=> $stable(s_reg.ninth_rx))
    else $error("Ninth receive bit changed without a received frame.");

endmodule
